// ==== rtl/dscl_port.sv ====
/*
 * Serial codec link port: double-buffered transmit and receive shifters,
 * frame-sync handling, register slave and interrupt logic.
 * Assumes bit clocks far slower than core_clk (at least four core cycles
 * per half period) and a register master that never overlaps strobes.
 */
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "dscl_defs.svh"

module dscl_port (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire dscl_pkg::dscl_bus_type bus_req,
    output logic [15:0] bus_rdata,
    input wire dscl_pkg::dscl_link_type link_in,
    output logic serial_tx_data,
    output logic tx_frame_sync_out,
    output logic tx_frame_sync_oe_b,
    output logic irq
);

    dscl_pkg::dscl_link_type lk;
    dscl_pkg::dscl_link_type lk_prev_q;

    dscl_sync #(
        .WIDTH(`DSCL_LINK_W)
    ) u_sync (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .async_in(link_in),
        .sync_out(lk)
    );

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            lk_prev_q <= '0;
        end else begin
            lk_prev_q <= lk;
        end
    end

    // Edges of the sampled bit clocks; the transmit and receive shifters do not move without them.
    logic tx_rise;
    logic tx_fall;
    logic rx_fall;
    assign tx_rise = lk.tx_bit_clock & ~lk_prev_q.tx_bit_clock;
    assign tx_fall = ~lk.tx_bit_clock & lk_prev_q.tx_bit_clock;
    assign rx_fall = ~lk.rx_bit_clock & lk_prev_q.rx_bit_clock;

    // Register group.
    dscl_pkg::dscl_ctrl_type ctrl_q, ctrl_d;
    dscl_pkg::dscl_irq_type sts_q, sts_d, en_q, en_d;
    logic [15:0] txbuf_q, txbuf_d, rdata_q, rdata_d, rxbuf_q, rxbuf_d;
    logic txfull_q, txfull_d, irq_q, irq_d, oe_b_q, oe_b_d;
    logic tx_load, tx_done, rx_done, txbuf_wr;
    logic [4:0] len;

    // Transmit group.
    dscl_pkg::dscl_tx_state_type tx_st_q, tx_st_d;
    logic [15:0] tx_sh_q, tx_sh_d;
    logic [4:0] tx_cnt_q, tx_cnt_d;
    logic tx_data_q, tx_data_d, fs_out_q, fs_out_d;
    logic tx_rearm_q, tx_rearm_d, fs_eff;
    logic [15:0] tx_word;

    // Receive group.
    dscl_pkg::dscl_rx_state_type rx_st_q, rx_st_d;
    logic [15:0] rx_sh_q, rx_sh_d, rx_new;
    logic [4:0] rx_cnt_q, rx_cnt_d;

    assign len = ctrl_q.word_length_bit ? `DSCL_LEN_BYTE : `DSCL_LEN_WORD;
    assign txbuf_wr = bus_req.wr && (bus_req.addr == `DSCL_OFS_TXBUF);

    always_comb begin
        ctrl_d = ctrl_q;
        en_d = en_q;
        txbuf_d = txbuf_q;
        txfull_d = txfull_q;
        sts_d = sts_q;
        rdata_d = 16'h0000;
        if (tx_load) begin
            txfull_d = 1'b0;
        end
        if (bus_req.wr) begin
            unique case (bus_req.addr)
                `DSCL_OFS_CTRL: ctrl_d = bus_req.wdata[`DSCL_CTRL_W-1:0];
                `DSCL_OFS_TXBUF: begin
                    txbuf_d = bus_req.wdata;
                    txfull_d = 1'b1;
                end
                `DSCL_OFS_INTEN: en_d = bus_req.wdata[`DSCL_IRQ_W-1:0];
                `DSCL_OFS_INTCLR: sts_d = sts_q & ~bus_req.wdata[`DSCL_IRQ_W-1:0];
                default: ;
            endcase
        end
        // A completion in the clearing cycle wins over the clear.
        if (rx_done) begin
            sts_d.rx_done = 1'b1;
        end
        if (tx_done) begin
            sts_d.tx_done = 1'b1;
        end
        if (bus_req.rd) begin
            unique case (bus_req.addr)
                `DSCL_OFS_CTRL: rdata_d = {12'h000, ctrl_q};
                `DSCL_OFS_TXBUF: rdata_d = txbuf_q;
                `DSCL_OFS_RXBUF: rdata_d = rxbuf_q;
                `DSCL_OFS_STATUS: rdata_d = {14'h0000, sts_q};
                `DSCL_OFS_INTEN: rdata_d = {14'h0000, en_q};
                `DSCL_OFS_STATE: rdata_d = {13'h0000, rx_st_q == dscl_pkg::DSCL_RX_SHIFT,
                    tx_st_q != dscl_pkg::DSCL_TX_IDLE, txfull_q};
                default: rdata_d = 16'h0000;
            endcase
        end
        irq_d = |(sts_d & en_d);
        oe_b_d = ~ctrl_d.tx_sync_direction_bit;
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= `DSCL_CTRL_RST;
            en_q <= `DSCL_INTEN_RST;
            sts_q <= '0;
            txbuf_q <= `DSCL_BUF_RST;
            txfull_q <= 1'b0;
            rdata_q <= 16'h0000;
            irq_q <= 1'b0;
            oe_b_q <= 1'b1;
        end else begin
            ctrl_q <= ctrl_d;
            en_q <= en_d;
            sts_q <= sts_d;
            txbuf_q <= txbuf_d;
            txfull_q <= txfull_d;
            rdata_q <= rdata_d;
            irq_q <= irq_d;
            oe_b_q <= oe_b_d;
        end
    end

    // Frame sync seen by the transmitter: own pulse or the far party's.
    assign fs_eff = ctrl_q.tx_sync_direction_bit ? fs_out_q : lk.tx_frame_sync;
    assign tx_word = ctrl_q.word_length_bit ? {txbuf_q[7:0], 8'h00} : txbuf_q;

    always_comb begin
        tx_st_d = tx_st_q;
        tx_sh_d = tx_sh_q;
        tx_cnt_d = tx_cnt_q;
        tx_data_d = tx_data_q;
        fs_out_d = fs_out_q;
        tx_rearm_d = tx_rearm_q;
        tx_load = 1'b0;
        tx_done = 1'b0;
        if (!ctrl_q.tx_sync_direction_bit) begin
            fs_out_d = 1'b0;
        end else if (tx_rise) begin
            // One bit-clock pulse when a loaded word waits and the port rests.
            fs_out_d = (tx_st_q == dscl_pkg::DSCL_TX_IDLE) && txfull_q && !fs_out_q;
        end
        unique case (tx_st_q)
            dscl_pkg::DSCL_TX_IDLE: begin
                if (tx_fall && fs_eff) begin
                    tx_st_d = dscl_pkg::DSCL_TX_ARMED;
                    tx_sh_d = tx_word;
                    tx_load = 1'b1;
                end
            end
            dscl_pkg::DSCL_TX_ARMED: begin
                if (tx_rise) begin
                    tx_data_d = tx_sh_q[15];
                    tx_sh_d = {tx_sh_q[14:0], 1'b0};
                    tx_cnt_d = 5'h01;
                    tx_rearm_d = 1'b0;
                    tx_st_d = dscl_pkg::DSCL_TX_SHIFT;
                end
            end
            dscl_pkg::DSCL_TX_SHIFT: begin
                if (tx_fall && fs_eff && ctrl_q.cont) begin
                    tx_rearm_d = 1'b1;
                end
                if (tx_rise) begin
                    if (tx_cnt_q == len) begin
                        tx_done = 1'b1;
                        tx_rearm_d = 1'b0;
                        if (ctrl_q.cont && (ctrl_q.cont_free || tx_rearm_q)) begin
                            tx_data_d = tx_word[15];
                            tx_sh_d = {tx_word[14:0], 1'b0};
                            tx_cnt_d = 5'h01;
                            tx_load = 1'b1;
                        end else begin
                            tx_st_d = dscl_pkg::DSCL_TX_IDLE;
                        end
                    end else begin
                        tx_data_d = tx_sh_q[15];
                        tx_sh_d = {tx_sh_q[14:0], 1'b0};
                        tx_cnt_d = tx_cnt_q + 5'h01;
                    end
                end
            end
            default: tx_st_d = dscl_pkg::DSCL_TX_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_st_q <= dscl_pkg::DSCL_TX_IDLE;
            tx_sh_q <= 16'h0000;
            tx_cnt_q <= 5'h00;
            tx_data_q <= 1'b0;
            fs_out_q <= 1'b0;
            tx_rearm_q <= 1'b0;
        end else begin
            tx_st_q <= tx_st_d;
            tx_sh_q <= tx_sh_d;
            tx_cnt_q <= tx_cnt_d;
            tx_data_q <= tx_data_d;
            fs_out_q <= fs_out_d;
            tx_rearm_q <= tx_rearm_d;
        end
    end

    // The receiver has its own clock and frame sync and never looks at
    // the transmitter.
    assign rx_new = {rx_sh_q[14:0], lk.serial_rx_data};

    always_comb begin
        rx_st_d = rx_st_q;
        rx_sh_d = rx_sh_q;
        rx_cnt_d = rx_cnt_q;
        rxbuf_d = rxbuf_q;
        rx_done = 1'b0;
        unique case (rx_st_q)
            dscl_pkg::DSCL_RX_IDLE: begin
                if (rx_fall && lk.rx_frame_sync) begin
                    rx_st_d = dscl_pkg::DSCL_RX_SHIFT;
                    rx_cnt_d = 5'h00;
                end
            end
            dscl_pkg::DSCL_RX_SHIFT: begin
                if (rx_fall) begin
                    rx_sh_d = rx_new;
                    rx_cnt_d = rx_cnt_q + 5'h01;
                    if (rx_cnt_q + 5'h01 == len) begin
                        rx_done = 1'b1;
                        rxbuf_d = ctrl_q.word_length_bit ?
                            {8'h00, rx_new[7:0]} : rx_new;
                        rx_cnt_d = 5'h00;
                        if (!(ctrl_q.cont &&
                              (ctrl_q.cont_free || lk.rx_frame_sync))) begin
                            rx_st_d = dscl_pkg::DSCL_RX_IDLE;
                        end
                    end
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_st_q <= dscl_pkg::DSCL_RX_IDLE;
            rx_sh_q <= 16'h0000;
            rx_cnt_q <= 5'h00;
            rxbuf_q <= `DSCL_BUF_RST;
        end else begin
            rx_st_q <= rx_st_d;
            rx_sh_q <= rx_sh_d;
            rx_cnt_q <= rx_cnt_d;
            rxbuf_q <= rxbuf_d;
        end
    end

    assign bus_rdata = rdata_q;
    assign serial_tx_data = tx_data_q;
    assign tx_frame_sync_out = fs_out_q;
    assign tx_frame_sync_oe_b = oe_b_q;
    assign irq = irq_q;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    a_tx_bit_hold: assert property (
        (tx_st_q == dscl_pkg::DSCL_TX_SHIFT && !tx_rise) |=> $stable(tx_data_q))
        else $error("Transmit bit changed without a bit clock rise.");
    a_rx_cnt_hold: assert property (
        (rx_st_q == dscl_pkg::DSCL_RX_SHIFT && !rx_fall) |=> $stable(rx_cnt_q))
        else $error("Receive count moved without a bit clock fall.");
    a_tx_start_sync: assert property (
        (tx_st_q == dscl_pkg::DSCL_TX_IDLE ##1 tx_st_q != dscl_pkg::DSCL_TX_IDLE)
        |-> $past(tx_fall && fs_eff))
        else $error("Transmit started without a frame pulse.");
    a_fs_drive_dir: assert property (
        ctrl_q.tx_sync_direction_bit == !tx_frame_sync_oe_b)
        else $error("Frame sync drive does not match direction bit.");
    a_tx_done_flag: assert property (
        tx_done |=> sts_q.tx_done ##1 (sts_q.tx_done || $past(bus_req.wr)))
        else $error("Transmit completion flag lost.");
    a_tx_word_len: assert property (
        tx_done |-> (tx_cnt_q == (ctrl_q.word_length_bit ? 5'h08 : 5'h10)))
        else $error("Transmit word had the wrong length.");
    a_rx_buf_copy: assert property (
        rx_done |=> (sts_q.rx_done && rxbuf_q == $past(rxbuf_d)))
        else $error("Receive buffer and flag not set together.");
    a_tx_buf_free: assert property (
        (tx_load && !txbuf_wr) |=> !txfull_q)
        else $error("Transmit buffer not freed on load.");
    a_irq_level: assert property (
        irq == |(sts_q & en_q))
        else $error("Interrupt output does not follow enabled status.");

endmodule : dscl_port

`default_nettype wire

// ==== rtl/dscl_defs.svh ====
/*
 * Register offsets, field widths, reset values and word lengths of the
 * serial codec link port.
 * Assumes it is included by bare name by the package and the port logic.
 */
// Overview of operation
// - Transmit bits change on transmit bit clock; receive bits sampled on receive clock.
// - Bit clocks may stop between transfers; no logic waits on a free clock.
// - Transmit and receive each have a buffer word apart from the shift register.
// - Burst transfers start on a pulse at their own frame-sync input.
// - A control bit makes transmit frame sync an input or a driven output.
// - Completed receive and transmit transfers each raise their own interrupt.
// - Continuous mode chains words back to back, with or without frame pulses.
// - A control bit selects 8-bit or 16-bit serial words.
// - Receive data pin shifts into the receive shift register feeding the buffer.
// - Transmit and receive frame syncs are unrelated; both sections run independently.
`ifndef DSCL_DEFS_SVH
`define DSCL_DEFS_SVH

`define DSCL_OFS_CTRL 8'h00
`define DSCL_OFS_TXBUF 8'h04
`define DSCL_OFS_RXBUF 8'h08
`define DSCL_OFS_STATUS 8'h0c
`define DSCL_OFS_INTEN 8'h10
`define DSCL_OFS_INTCLR 8'h14
`define DSCL_OFS_STATE 8'h18

`define DSCL_CTRL_W 4
`define DSCL_IRQ_W 2
`define DSCL_CTRL_RST 4'h0
`define DSCL_INTEN_RST 2'h0
`define DSCL_BUF_RST 16'h0000

`define DSCL_LEN_BYTE 5'h08
`define DSCL_LEN_WORD 5'h10
`define DSCL_LINK_W 5

`endif

// ==== rtl/dscl_pkg.sv ====
/*
 * Types shared by the serial codec link port.
 * Assumes the constant header sits beside it.
 */
`include "dscl_defs.svh"

package dscl_pkg;

    typedef struct packed {
        logic cont_free;
        logic cont;
        logic word_length_bit;
        logic tx_sync_direction_bit;
    } dscl_ctrl_type;

    typedef struct packed {
        logic tx_done;
        logic rx_done;
    } dscl_irq_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } dscl_bus_type;

    typedef struct packed {
        logic tx_bit_clock;
        logic rx_bit_clock;
        logic tx_frame_sync;
        logic rx_frame_sync;
        logic serial_rx_data;
    } dscl_link_type;

    typedef enum logic [1:0] {
        DSCL_TX_IDLE,
        DSCL_TX_ARMED,
        DSCL_TX_SHIFT
    } dscl_tx_state_type;

    typedef enum logic {
        DSCL_RX_IDLE,
        DSCL_RX_SHIFT
    } dscl_rx_state_type;

endpackage : dscl_pkg

// ==== rtl/dscl_sync.sv ====
/*
 * Two-stage synchroniser for the link pins, one chain per bit.
 * Assumes inputs are asynchronous to core_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module dscl_sync #(
    parameter int WIDTH = 5
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic meta_q;
            logic sync_q;
            always_ff @(posedge core_clk or negedge rst_b) begin
                if (!rst_b) begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                end else begin
                    meta_q <= async_in[i];
                    sync_q <= meta_q;
                end
            end
            assign sync_out[i] = sync_q;
        end
    endgenerate

endmodule : dscl_sync

`default_nettype wire

// ==== dv/dscl_codec_model.sv ====
/*
 * Behavioural far-side converter: bit clocks, frame syncs, receive data
 * and capture of transmit data.
 * Assumes the bench calls its tasks and routes the transmit sync pin.
 */
`timescale 1ns/1ps
`default_nettype none

module dscl_codec_model (
    input wire logic serial_tx_data,
    input wire logic fs_pin,
    output logic tx_bit_clock,
    output logic rx_bit_clock,
    output logic tx_frame_sync,
    output logic rx_frame_sync,
    output logic serial_rx_data
);
    logic fs_seen = 1'b0;
    logic tx_end_of_data_pulse = 1'b1;
    logic rx_end_of_data_pulse = 1'b1;

    // The codec frame pulse comes from the system clock divided twice.
    localparam real SYS_CLK_NS = 1.0e9 / 40.96e6;
    localparam int MCLK_DIV = 20;
    localparam int FRAME_DIV = 256;
    localparam real FRAME_NS = SYS_CLK_NS * MCLK_DIV * FRAME_DIV;

    initial begin
        tx_bit_clock = 1'b0;
        rx_bit_clock = 1'b0;
        tx_frame_sync = 1'b0;
        rx_frame_sync = 1'b0;
        serial_rx_data = 1'b0;
    end

    // Clocks toggle only inside one framed transfer and rest low after.
    task automatic tx_run(input int nbits, input int hp,
                          output logic [15:0] cap);
        cap = 16'h0000;
        tx_frame_sync = 1'b1;
        #hp tx_bit_clock = 1'b1;
        #hp tx_bit_clock = 1'b0;
        fs_seen = fs_pin;
        #(hp / 2) tx_frame_sync = 1'b0;
        for (int k = 0; k <= nbits; k++) begin
            #hp tx_bit_clock = 1'b1;
            #hp tx_bit_clock = 1'b0;
            if (k < nbits) begin
                cap = {cap[14:0], serial_tx_data};
            end
        end
        tx_end_of_data_pulse = 1'b0;
        #hp tx_end_of_data_pulse = 1'b1;
    endtask : tx_run

    // Data changes on rising edges and is inverted one half period after the word.
    task automatic rx_run(input logic [15:0] word, input int nbits,
                          input int hp);
        rx_frame_sync = 1'b1;
        #hp rx_bit_clock = 1'b1;
        #hp rx_bit_clock = 1'b0;
        #(hp / 2) rx_frame_sync = 1'b0;
        for (int k = nbits - 1; k >= 0; k--) begin
            #hp rx_bit_clock = 1'b1;
            serial_rx_data = word[k];
            #hp rx_bit_clock = 1'b0;
        end
        rx_end_of_data_pulse = 1'b0;
        #hp serial_rx_data = ~serial_rx_data;
        rx_end_of_data_pulse = 1'b1;
    endtask : rx_run
endmodule : dscl_codec_model
`default_nettype wire

// ==== dv/test_dscl_port.sv ====
/*
 * Self-checking bench of the serial codec link port with a converter model.
 * Assumes the port, its package and header are compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dscl_defs.svh"

module test_dscl_port;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    dscl_pkg::dscl_bus_type bus_req = '0;
    dscl_pkg::dscl_link_type link_in;
    logic [15:0] bus_rdata;
    logic serial_tx_data, fs_out, oe_b, irq, fs_pin;
    logic m_txc, m_rxc, m_txfs, m_rxfs, m_rxd;
    logic [15:0] cap, txw, rxw, mask;
    int error_cnt = 0;
    int total_checks = 0;
    int cycles = 0;
    int seed = 32'haf26e3bf;
    int nb, hp;

    always #25 core_clk = ~core_clk;
    assign fs_pin = oe_b ? m_txfs : fs_out;
    assign link_in = {m_txc, m_rxc, fs_pin, m_rxfs, m_rxd};

    dscl_port i_dscl_port (
        .core_clk(core_clk), .rst_b(rst_b), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .link_in(link_in),
        .serial_tx_data(serial_tx_data), .tx_frame_sync_out(fs_out),
        .tx_frame_sync_oe_b(oe_b), .irq(irq));

    dscl_codec_model i_dscl_codec_model (
        .serial_tx_data(serial_tx_data), .fs_pin(fs_pin),
        .tx_bit_clock(m_txc), .rx_bit_clock(m_rxc),
        .tx_frame_sync(m_txfs), .rx_frame_sync(m_rxfs),
        .serial_rx_data(m_rxd));

    task automatic check(input string n, input logic [15:0] e,
                         input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus_req.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [15:0] e,
                      input string n);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus_req.rd <= 1'b0;
        @(negedge core_clk);
        check(n, e, bus_rdata);
    endtask : rd

    task automatic results;
        $display("Checks %0d, errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : results

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 12000) begin
            error_cnt++;
            results();
        end
    end

    initial begin
        repeat (6) @(posedge core_clk);
        rst_b <= 1'b1;
        check("idle pins", 16'h0008, {12'h0, oe_b, irq, serial_tx_data, fs_out});
        check("frame period", 16'h007d, 16'($rtoi(i_dscl_codec_model.FRAME_NS / 1000.0 + 0.5)));
        for (int i = 0; i < 8; i++) begin
            rd(8'(i * 4), 16'h0000, "reset value");
        end
        for (int m = 0; m < 4; m++) begin
            nb = m[0] ? 8 : 16;
            hp = 200 + 65 * m;
            mask = m[0] ? 16'h00ff : 16'hffff;
            txw = 16'($random(seed));
            rxw = 16'($random(seed));
            wr(`DSCL_OFS_CTRL, {14'h0, m[0], m[1]});
            wr(`DSCL_OFS_TXBUF, txw);
            rd(`DSCL_OFS_STATE, 16'h0001, "tx buffer full");
            check("sync enable", {15'h0, ~m[1]}, {15'h0, oe_b});
            fork
                i_dscl_codec_model.tx_run(nb, hp, cap);
                i_dscl_codec_model.rx_run(rxw, nb, hp + 37);
            join
            repeat (8) @(posedge core_clk);
            check("sync at start", 16'h0001, {15'h0, i_dscl_codec_model.fs_seen});
            check("tx word", txw & mask, cap);
            rd(`DSCL_OFS_RXBUF, rxw & mask, "rx word");
            rd(`DSCL_OFS_STATUS, 16'h0003, "status");
            rd(`DSCL_OFS_STATE, 16'h0000, "state idle");
            wr(`DSCL_OFS_INTCLR, 16'h0003);
        end
        wr(`DSCL_OFS_INTEN, 16'h0001);
        wr(`DSCL_OFS_TXBUF, txw);
        i_dscl_codec_model.tx_run(8, 200, cap);
        repeat (8) @(posedge core_clk);
        rd(`DSCL_OFS_STATUS, 16'h0002, "tx only status");
        check("irq masked", 16'h0000, {15'h0, irq});
        wr(`DSCL_OFS_INTEN, 16'h0002);
        repeat (3) @(posedge core_clk);
        check("irq raised", 16'h0001, {15'h0, irq});
        wr(`DSCL_OFS_INTCLR, 16'h0002);
        repeat (3) @(posedge core_clk);
        check("irq cleared", 16'h0000, {15'h0, irq});
        rd(`DSCL_OFS_STATUS, 16'h0000, "status cleared");
        txw = 16'($random(seed));
        rxw = 16'($random(seed));
        wr(`DSCL_OFS_CTRL, 16'h000e);
        wr(`DSCL_OFS_TXBUF, txw);
        fork
            i_dscl_codec_model.tx_run(16, 200, cap);
            begin
                repeat (40) @(posedge core_clk);
                wr(`DSCL_OFS_TXBUF, rxw);
            end
        join
        check("chained words", {txw[7:0], rxw[7:0]}, cap);
        results();
    end
endmodule : test_dscl_port
`default_nettype wire
